// ---- hw/charger_device.sv ----
`timescale 1ns/100ps
`include "charger_map.svh"
module charger_device #(
  parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES,
  parameter int unsigned IRQ_PULSE_CYCLES = `IRQ_PULSE_CYCLES,
  parameter int unsigned SHIP_EXIT_CYCLES = `SHIP_EXIT_CYCLES,
  parameter int unsigned SYS_RESET_CYCLES = `SYS_RESET_CYCLES,
  parameter int unsigned SWITCH_OFF_CYCLES = `SWITCH_OFF_CYCLES,
  parameter int unsigned ILIM_BASE_MA = `ILIM_BASE_MA,
  parameter int unsigned ILIM_STEP_MA = `ILIM_STEP_MA
) (
  charger_if.device pins,                      // Pin side
  input wire logic clk_i,                      // Clock
  input wire logic rst_i,                      // Synchronous reset
  input wire logic input_above_input_undervoltage_lockout_i,         // Input above undervoltage lockout
  input wire logic input_below_ovp_i,          // Input below overvoltage
  input wire logic input_above_sleep_i,        // Input above sleep threshold
  input wire logic host_link_up_i,             // Serial link established
  input wire logic ilim_write_i,               // Pulse: limit field written
  input wire logic [4:0] input_current_limit_field_i, // Written limit code
  input wire logic [1:0] indicator_pin_mode_field_i,  // Status pin mode
  input wire logic charge_config_bit_i,        // Charge configuration bit
  input wire logic battery_switch_disable_i,   // Switch disable bit
  input wire logic thermistor_in_window_i,     // Thermistor inside window
  input wire logic charge_in_progress_i,       // Charge cycle running
  input wire logic charge_done_i,              // Charge completed
  input wire logic charger_sleep_i,            // Charger in sleep
  input wire logic charge_fault_i,             // Charge suspended by fault
  input wire logic status_update_i,            // Pulse: new status
  input wire logic source_present_i,           // Input source present
  input wire logic battery_present_i,          // Battery present
  input wire logic ship_mode_enter_i,          // Pulse: enter ship mode
  output logic [11:0] input_limit_ma_o,        // Applied limit in mA
  output logic charge_enable_o,                // Charging allowed
  output logic charge_suspend_o,               // Charging suspended by thermistor
  output logic battery_switch_on_o,            // Battery switch closed
  output logic ship_mode_o,                    // In ship mode
  output logic system_reset_o                  // Switch held off for reset
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] pin_reg;
  logic select_high;
  logic enable_low;
  logic ctrl_low;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= `DEV_PIN_IDLE;
      sync2_reg <= `DEV_PIN_IDLE;
      sync3_reg <= `DEV_PIN_IDLE;
      pin_reg <= `DEV_PIN_IDLE;
    end else begin
      sync1_reg <= {pins.switch_ctrl_level, pins.charge_enable_n, pins.source_select};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // A bit follows only once the second and third stages agree.
      pin_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (pin_reg & (sync2_reg ^ sync3_reg));
    end
  end

  assign select_high = pin_reg[0];
  assign enable_low = ~pin_reg[1];
  assign ctrl_low = ~pin_reg[2];

  // ****************************************************************
  // Input current limit and power good
  // ****************************************************************
  logic override_valid_reg;
  logic [4:0] override_code_reg;
  logic [11:0] limit_reg;
  logic pg_oe_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      override_valid_reg <= 1'b0;
      override_code_reg <= 5'h00;
    end else if (!host_link_up_i) begin
      override_valid_reg <= 1'b0;
    end else if (ilim_write_i) begin
      override_valid_reg <= 1'b1;
      override_code_reg <= input_current_limit_field_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit_reg <= `PSEL_LOW_LIMIT_MA;
    end else if (override_valid_reg) begin
      limit_reg <= 12'(ILIM_BASE_MA + 32'(override_code_reg) * ILIM_STEP_MA);
    end else begin
      limit_reg <= select_high ? `PSEL_HIGH_LIMIT_MA : `PSEL_LOW_LIMIT_MA;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pg_oe_reg <= 1'b0;
    end else begin
      pg_oe_reg <= input_above_input_undervoltage_lockout_i & input_below_ovp_i & input_above_sleep_i
                   & (limit_reg > `PG_MIN_LIMIT_MA);
    end
  end

  assign input_limit_ma_o = limit_reg;
  assign pins.power_good_out = 1'b0;
  assign pins.power_good_oe = pg_oe_reg;

  // ****************************************************************
  // Charge qualification
  // ****************************************************************
  logic enable_reg;
  logic suspend_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_reg <= 1'b0;
      suspend_reg <= 1'b0;
    end else begin
      suspend_reg <= ~thermistor_in_window_i;
      enable_reg <= charge_config_bit_i & enable_low & thermistor_in_window_i;
    end
  end

  assign charge_enable_o = enable_reg;
  assign charge_suspend_o = suspend_reg;

  // ****************************************************************
  // Charge status pin
  // ****************************************************************
  logic [31:0] blink_cnt_reg;
  logic blink_phase_reg;
  logic stat_oe_reg;

  // The blink restarts in its low half each time a fault begins.
  always_ff @(posedge clk_i) begin
    if (rst_i || !charge_fault_i) begin
      blink_cnt_reg <= 32'h0;
      blink_phase_reg <= 1'b0;
    end else if (blink_cnt_reg == 32'(BLINK_HALF_CYCLES - 1)) begin
      blink_cnt_reg <= 32'h0;
      blink_phase_reg <= ~blink_phase_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_oe_reg <= 1'b0;
    end else if (indicator_pin_mode_field_i == `IND_MODE_OFF) begin
      stat_oe_reg <= 1'b0;
    end else if (charge_fault_i) begin
      stat_oe_reg <= ~blink_phase_reg;
    end else if (charge_done_i || charger_sleep_i) begin
      stat_oe_reg <= 1'b0;
    end else begin
      stat_oe_reg <= charge_in_progress_i;
    end
  end

  assign pins.status_out = 1'b0;
  assign pins.status_oe = stat_oe_reg;

  // ****************************************************************
  // Interrupt pulse
  // ****************************************************************
  logic fault_d_reg;
  logic irq_pending_reg;
  logic irq_active_reg;
  logic [31:0] irq_cnt_reg;
  logic irq_event;

  assign irq_event = status_update_i | (charge_fault_i & ~fault_d_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_d_reg <= 1'b0;
    end else begin
      fault_d_reg <= charge_fault_i;
    end
  end

  // Events during a pulse are held and give one more pulse afterwards.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_pending_reg <= 1'b0;
    end else if (irq_event) begin
      irq_pending_reg <= 1'b1;
    end else if (!irq_active_reg) begin
      irq_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_active_reg <= 1'b0;
      irq_cnt_reg <= 32'h0;
    end else if (irq_active_reg) begin
      if (irq_cnt_reg == 32'(IRQ_PULSE_CYCLES - 1)) begin
        irq_active_reg <= 1'b0;
      end
      irq_cnt_reg <= irq_cnt_reg + 32'h1;
    end else if (irq_pending_reg) begin
      irq_active_reg <= 1'b1;
      irq_cnt_reg <= 32'h0;
    end
  end

  assign pins.irq_out = 1'b0;
  assign pins.irq_oe = irq_active_reg;

  // ****************************************************************
  // Battery switch control
  // ****************************************************************
  charger_pkg::switch_state_t state_reg;
  logic [31:0] low_cnt_reg;
  logic [31:0] off_cnt_reg;
  logic pullup_reg;
  logic ship_hit;
  logic reset_hit;

  // The count saturates past the longest threshold so each hit fires once.
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_low) begin
      low_cnt_reg <= 32'h0;
    end else if (low_cnt_reg != 32'(SYS_RESET_CYCLES)) begin
      low_cnt_reg <= low_cnt_reg + 32'h1;
    end
  end

  assign ship_hit = ctrl_low && (low_cnt_reg == 32'(SHIP_EXIT_CYCLES - 1));
  assign reset_hit = ctrl_low && (low_cnt_reg == 32'(SYS_RESET_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= charger_pkg::SW_ON;
      off_cnt_reg <= 32'h0;
    end else begin
      unique case (state_reg)
        charger_pkg::SW_ON: begin
          if (ship_mode_enter_i) begin
            state_reg <= charger_pkg::SW_SHIP;
          end else if (reset_hit && !source_present_i) begin
            state_reg <= charger_pkg::SW_RESET_OFF;
            off_cnt_reg <= 32'h0;
          end
        end
        charger_pkg::SW_SHIP: begin
          if (ship_hit) begin
            state_reg <= charger_pkg::SW_ON;
          end
        end
        charger_pkg::SW_RESET_OFF: begin
          if (off_cnt_reg == 32'(SWITCH_OFF_CYCLES - 1)) begin
            state_reg <= charger_pkg::SW_ON;
          end
          off_cnt_reg <= off_cnt_reg + 32'h1;
        end
        default: begin
          state_reg <= charger_pkg::SW_ON;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pullup_reg <= 1'b0;
    end else begin
      pullup_reg <= source_present_i | battery_present_i;
    end
  end

  assign pins.switch_ctrl_pullup = pullup_reg;
  assign battery_switch_on_o = (state_reg == charger_pkg::SW_ON) && !battery_switch_disable_i;
  assign ship_mode_o = (state_reg == charger_pkg::SW_SHIP);
  assign system_reset_o = (state_reg == charger_pkg::SW_RESET_OFF);

endmodule

// ---- hw/charger_map.svh ----
`ifndef CHARGER_MAP_SVH
`define CHARGER_MAP_SVH

// ****************************************************************
// Timebase
// ****************************************************************
`define CLK_HZ 125000000
`define CLK_PER_MS (`CLK_HZ / 1000)
`define CLK_PER_US (`CLK_HZ / 1000000)

// ****************************************************************
// Input current limit
// ****************************************************************
`define PSEL_HIGH_LIMIT_MA 12'h1f4
`define PSEL_LOW_LIMIT_MA 12'h960
`define PG_MIN_LIMIT_MA 12'h01e
`define ILIM_BASE_MA 100
`define ILIM_STEP_MA 100

// ****************************************************************
// Indicator pins
// ****************************************************************
`define BLINK_FREQ_HZ 1
`define BLINK_HALF_CYCLES (`CLK_HZ / (2 * `BLINK_FREQ_HZ))
`define IRQ_PULSE_US 256
`define IRQ_PULSE_CYCLES (`IRQ_PULSE_US * `CLK_PER_US)
`define IND_MODE_OFF 2'h3

// ****************************************************************
// Battery switch control pulses
// ****************************************************************
`define SHIP_EXIT_PULSE_S 1
`define SHIP_EXIT_CYCLES (`SHIP_EXIT_PULSE_S * `CLK_HZ)
`define SYS_RESET_PULSE_S 16
`define SYS_RESET_CYCLES (`SYS_RESET_PULSE_S * `CLK_HZ)
`define SWITCH_OFF_RESET_MS 250
`define SWITCH_OFF_CYCLES (`SWITCH_OFF_RESET_MS * `CLK_PER_MS)
`define HOST_HOLD_MARGIN 16

// ****************************************************************
// Pin idle levels, device order {switch_ctrl_n, enable_n, select}, host order {host_irq_n, status_level, power_good_n}
// ****************************************************************
`define DEV_PIN_IDLE 3'h6
`define HOST_PIN_IDLE 3'h7

`endif

// ---- hw/charger_pkg.sv ----
package charger_pkg;
  typedef enum logic [1:0] {
    SW_ON = 2'b00,
    SW_SHIP = 2'b01,
    SW_RESET_OFF = 2'b10
  } switch_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_HOLD = 2'b01
  } host_state_t;
endpackage

// ---- hw/charger_if.sv ----
`timescale 1ns/100ps
interface charger_if;
  logic source_select;
  logic charge_enable_n;
  logic switch_ctrl_out;
  logic switch_ctrl_oe;
  logic switch_ctrl_pullup;
  logic switch_ctrl_level;
  logic power_good_out;
  logic power_good_oe;
  logic power_good_n;
  logic status_out;
  logic status_oe;
  logic status_level;
  logic irq_out;
  logic irq_oe;
  logic host_irq_n;

  // The external pull-ups on the power good, status and interrupt lines read high when nobody drives; the control line reads the device pull-up.
  assign switch_ctrl_level = switch_ctrl_oe ? switch_ctrl_out : switch_ctrl_pullup;
  assign power_good_n = power_good_oe ? power_good_out : 1'b1;
  assign status_level = status_oe ? status_out : 1'b1;
  assign host_irq_n = irq_oe ? irq_out : 1'b1;

  modport device (
    input source_select, charge_enable_n, switch_ctrl_level,
    output switch_ctrl_pullup, power_good_out, power_good_oe, status_out, status_oe, irq_out, irq_oe
  );
  modport host (
    output source_select, charge_enable_n, switch_ctrl_out, switch_ctrl_oe,
    input switch_ctrl_level, power_good_n, status_level, host_irq_n
  );
endinterface

// ---- hw/charger_host.sv ----
`timescale 1ns/100ps
`include "charger_map.svh"
module charger_host #(
  parameter int unsigned WAKE_HOLD_CYCLES = `SHIP_EXIT_CYCLES + `HOST_HOLD_MARGIN,
  parameter int unsigned RESET_HOLD_CYCLES = `SYS_RESET_CYCLES + `HOST_HOLD_MARGIN
) (
  charger_if.host pins,              // Pin side
  input wire logic clk_i,            // Clock
  input wire logic rst_i,            // Synchronous reset
  input wire logic source_select_i,  // Level for the source-select pin
  input wire logic charge_enable_i,  // High requests charging
  input wire logic wake_request_i,   // Pulse: leave ship mode
  input wire logic reset_request_i,  // Pulse: full system reset pulse
  output logic busy_o,               // Control pulse in progress
  output logic power_good_o,         // Input reported good
  output logic charging_o,           // Status pin low
  output logic irq_o                 // Pulse: interrupt seen
);

  // ****************************************************************
  // Static control pins
  // ****************************************************************
  logic select_reg;
  logic enable_n_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      select_reg <= 1'b0;
      enable_n_reg <= 1'b1;
    end else begin
      select_reg <= source_select_i;
      enable_n_reg <= ~charge_enable_i;
    end
  end

  assign pins.source_select = select_reg;
  assign pins.charge_enable_n = enable_n_reg;

  // ****************************************************************
  // Switch control pulse
  // ****************************************************************
  charger_pkg::host_state_t state_reg;
  logic [31:0] hold_cnt_reg;

  // Requests that arrive while a pulse runs are ignored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= charger_pkg::H_IDLE;
      hold_cnt_reg <= 32'h0;
    end else begin
      unique case (state_reg)
        charger_pkg::H_IDLE: begin
          if (reset_request_i) begin
            state_reg <= charger_pkg::H_HOLD;
            hold_cnt_reg <= 32'(RESET_HOLD_CYCLES - 1);
          end else if (wake_request_i) begin
            state_reg <= charger_pkg::H_HOLD;
            hold_cnt_reg <= 32'(WAKE_HOLD_CYCLES - 1);
          end
        end
        charger_pkg::H_HOLD: begin
          if (hold_cnt_reg == 32'h0) begin
            state_reg <= charger_pkg::H_IDLE;
          end else begin
            hold_cnt_reg <= hold_cnt_reg - 32'h1;
          end
        end
        default: begin
          state_reg <= charger_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign pins.switch_ctrl_out = 1'b0;
  assign pins.switch_ctrl_oe = (state_reg == charger_pkg::H_HOLD);
  assign busy_o = (state_reg == charger_pkg::H_HOLD);

  // ****************************************************************
  // Indicator inputs
  // ****************************************************************
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] pin_reg;
  logic irq_d_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= `HOST_PIN_IDLE;
      sync2_reg <= `HOST_PIN_IDLE;
      sync3_reg <= `HOST_PIN_IDLE;
      pin_reg <= `HOST_PIN_IDLE;
      irq_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {pins.host_irq_n, pins.status_level, pins.power_good_n};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (pin_reg & (sync2_reg ^ sync3_reg));
      irq_d_reg <= pin_reg[2];
    end
  end

  assign power_good_o = ~pin_reg[0];
  assign charging_o = ~pin_reg[1];
  assign irq_o = irq_d_reg & ~pin_reg[2];

endmodule

// ---- tb/charger_pins_sva.sv ----
`timescale 1ns/100ps
module charger_pins_sva #(
  parameter int unsigned IRQ_PULSE_CYCLES = 8,
  parameter int unsigned WAKE_HOLD_CYCLES = 40,
  parameter int unsigned RESET_HOLD_CYCLES = 80
) (
  input wire logic clk_i,             // Clock
  input wire logic rst_i,             // Synchronous reset
  input wire logic switch_ctrl_pullup, // Device pull-up on
  input wire logic switch_ctrl_oe,    // Host pulls low
  input wire logic switch_ctrl_level, // Resolved line
  input wire logic power_good_n,      // Resolved line
  input wire logic power_good_oe,     // Device pulls low
  input wire logic status_level,      // Resolved line
  input wire logic status_oe,         // Device pulls low
  input wire logic host_irq_n,        // Resolved line
  input wire logic irq_oe             // Device pulls low
);
  // ****************************************************************
  // Run lengths of the driven-low spans
  // ****************************************************************
  // Counting in helper logic keeps the long spans out of unrolled repetitions.
  logic [15:0] irq_run_reg;
  logic [15:0] hold_run_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || !irq_oe) irq_run_reg <= 16'h0000;
    else irq_run_reg <= irq_run_reg + 16'h0001;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !switch_ctrl_oe) hold_run_reg <= 16'h0000;
    else hold_run_reg <= hold_run_reg + 16'h0001;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_irq_len;
    (!irq_oe && irq_run_reg != 16'h0000) |-> irq_run_reg == 16'(IRQ_PULSE_CYCLES);
  endproperty
  property p_hold_len;
    (!switch_ctrl_oe && hold_run_reg != 16'h0000) |->
      (hold_run_reg == 16'(WAKE_HOLD_CYCLES) || hold_run_reg == 16'(RESET_HOLD_CYCLES));
  endproperty
  property p_hold_min;
    $rose(switch_ctrl_oe) |=> switch_ctrl_oe [*8];
  endproperty
  property p_hold_low;
    switch_ctrl_oe |-> !switch_ctrl_level;
  endproperty
  property p_pg_drive;
    power_good_oe |-> !power_good_n;
  endproperty
  property p_stat_drive;
    status_oe |-> !status_level;
  endproperty
  property p_irq_drive;
    irq_oe |-> !host_irq_n;
  endproperty
  property p_ctrl_drive;
    !switch_ctrl_oe |-> switch_ctrl_level == switch_ctrl_pullup;
  endproperty

  a_irq_len: assert property (p_irq_len) else $error("interrupt pulse length wrong");
  a_hold_len: assert property (p_hold_len) else $error("control hold length wrong");
  a_hold_min: assert property (p_hold_min) else $error("control hold too short");
  a_hold_low: assert property (p_hold_low) else $error("control line not low while held");
  a_pg_drive: assert property (p_pg_drive) else $error("power good line high while driven");
  a_stat_drive: assert property (p_stat_drive) else $error("status line high while driven");
  a_irq_drive: assert property (p_irq_drive) else $error("interrupt line high while driven");
  a_ctrl_drive: assert property (p_ctrl_drive) else $error("control line differs from pull-up");

  c_irq: cover property ($rose(irq_oe));
  c_hold: cover property ($rose(switch_ctrl_oe));
  c_blink: cover property ($fell(status_oe));
endmodule

// ---- tb/charger_control_pin_logic_test.sv ----
`timescale 1ns/100ps
module charger_control_pin_logic_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic input_undervoltage_lockout_ok = 1'b1, ovp_ok = 1'b1, sleep_ok = 1'b1, link_up = 1'b0, ilim_wr = 1'b0;
  logic [4:0] code = 5'h00;
  logic [1:0] mode = 2'h0;
  logic cfg = 1'b0, sw_dis = 1'b0, therm = 1'b1, in_prog = 1'b0, done = 1'b0, asleep = 1'b0;
  logic fault = 1'b0, upd = 1'b0, src_pres = 1'b1, bat_pres = 1'b1, ship_in = 1'b0;
  logic src_sel = 1'b0, en = 1'b0, wake_req = 1'b0, rst_req = 1'b0;
  logic [11:0] limit_ma;
  logic chg_en, suspend, sw_on, ship, sys_rst, busy, pg, charging, irq_seen;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  int n_irq = 0;

  always #4 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (irq_seen === 1'b1) n_irq++;
  end

  charger_if pins();
  charger_device #(.BLINK_HALF_CYCLES(8), .IRQ_PULSE_CYCLES(8), .SHIP_EXIT_CYCLES(20),
    .SYS_RESET_CYCLES(60), .SWITCH_OFF_CYCLES(10)) u_charger_device (
    .pins(pins), .clk_i(clk_i), .rst_i(rst_i), .input_above_input_undervoltage_lockout_i(input_undervoltage_lockout_ok), .input_below_ovp_i(ovp_ok),
    .input_above_sleep_i(sleep_ok), .host_link_up_i(link_up), .ilim_write_i(ilim_wr),
    .input_current_limit_field_i(code), .indicator_pin_mode_field_i(mode), .charge_config_bit_i(cfg),
    .battery_switch_disable_i(sw_dis), .thermistor_in_window_i(therm), .charge_in_progress_i(in_prog),
    .charge_done_i(done), .charger_sleep_i(asleep), .charge_fault_i(fault), .status_update_i(upd),
    .source_present_i(src_pres), .battery_present_i(bat_pres), .ship_mode_enter_i(ship_in),
    .input_limit_ma_o(limit_ma), .charge_enable_o(chg_en), .charge_suspend_o(suspend),
    .battery_switch_on_o(sw_on), .ship_mode_o(ship), .system_reset_o(sys_rst));
  charger_host #(.WAKE_HOLD_CYCLES(40), .RESET_HOLD_CYCLES(80)) u_charger_host (
    .pins(pins), .clk_i(clk_i), .rst_i(rst_i), .source_select_i(src_sel), .charge_enable_i(en),
    .wake_request_i(wake_req), .reset_request_i(rst_req), .busy_o(busy), .power_good_o(pg),
    .charging_o(charging), .irq_o(irq_seen));
  charger_pins_sva u_charger_pins_sva (
    .clk_i(clk_i), .rst_i(rst_i), .switch_ctrl_pullup(pins.switch_ctrl_pullup),
    .switch_ctrl_oe(pins.switch_ctrl_oe), .switch_ctrl_level(pins.switch_ctrl_level),
    .power_good_oe(pins.power_good_oe), .power_good_n(pins.power_good_n), .status_oe(pins.status_oe),
    .status_level(pins.status_level), .irq_oe(pins.irq_oe), .host_irq_n(pins.host_irq_n));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  function automatic logic sig(input int sel);
    case (sel)
      0: return pins.status_oe;
      1: return pins.irq_oe;
      2: return pins.switch_ctrl_oe;
      3: return sys_rst;
      default: return busy;
    endcase
  endfunction
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_ma(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input int sel, input logic v);
    int k;
    k = 0;
    while (sig(sel) !== v && k < 300) begin
      step(1);
      k++;
    end
    check_bit(sig(sel), v);
  endtask
  // The span is counted from the first cycle at level v up to the change.
  task automatic run_len(input int sel, input logic v, output int len);
    len = 0;
    while (sig(sel) === v && len < 1000) begin
      step(1);
      len++;
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clk_i);
    case (k)
      0: ilim_wr <= 1'b1;
      1: upd <= 1'b1;
      2: ship_in <= 1'b1;
      3: wake_req <= 1'b1;
      default: rst_req <= 1'b1;
    endcase
    @(posedge clk_i);
    {ilim_wr, upd, ship_in, wake_req, rst_req} <= 5'h00;
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #80000;
    n_mismatch++;
    final_report();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    step(2);
    check_ma(limit_ma, 12'h960);
    check_bit(pins.switch_ctrl_pullup, 1'b0);
    check_bit(pins.irq_oe, 1'b0);
    check_bit(pins.charge_enable_n, 1'b1);
    @(posedge clk_i) rst_i <= 1'b0;
    @(posedge clk_i) src_sel <= 1'b1;
    step(12);
    check_ma(limit_ma, 12'h1f4);
    check_bit(pins.switch_ctrl_pullup, 1'b1);
    @(posedge clk_i) src_sel <= 1'b0;
    step(12);
    check_ma(limit_ma, 12'h960);
    $display("test limit select done");
    @(posedge clk_i) link_up <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i) code <= i ? 5'h1f : 5'h00;
      pulse(0);
      step(2);
      check_ma(limit_ma, i ? 12'hc80 : 12'h064);
    end
    @(posedge clk_i) link_up <= 1'b0;
    step(3);
    check_ma(limit_ma, 12'h960);
    $display("test limit override done");
    check_bit(pg, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i) {input_undervoltage_lockout_ok, ovp_ok, sleep_ok} <= 3'h7 ^ (3'h1 << i);
      step(12);
      check_bit(pins.power_good_n, 1'b1);
      check_bit(pg, 1'b0);
      @(posedge clk_i) {input_undervoltage_lockout_ok, ovp_ok, sleep_ok} <= 3'h7;
      step(12);
      check_bit(pins.power_good_n, 1'b0);
    end
    $display("test power good done");
    @(posedge clk_i) in_prog <= 1'b1;
    step(12);
    check_bit(charging, 1'b1);
    @(posedge clk_i) done <= 1'b1;
    step(12);
    check_bit(charging, 1'b0);
    @(posedge clk_i) {done, asleep} <= 2'b01;
    step(12);
    check_bit(pins.status_level, 1'b1);
    @(posedge clk_i) {asleep, fault} <= 2'b01;
    wait_for(0, 1'b1);
    run_len(0, 1'b1, n);
    check_cnt(n, 8);
    run_len(0, 1'b0, n);
    check_cnt(n, 8);
    @(posedge clk_i) mode <= 2'h3;
    step(4);
    check_bit(pins.status_level, 1'b1);
    step(12);
    check_bit(pins.status_oe, 1'b0);
    @(posedge clk_i) {mode, fault, in_prog} <= 4'h0;
    $display("test status pin done");
    step(40);
    pulse(1);
    wait_for(1, 1'b1);
    // The second update lands inside the first pulse and must be queued.
    fork
      run_len(1, 1'b1, n);
      pulse(1);
    join
    check_cnt(n, 8);
    wait_for(1, 1'b1);
    run_len(1, 1'b1, n);
    check_cnt(n, 8);
    step(20);
    check_bit(pins.host_irq_n, 1'b1);
    // The one-cycle gap between queued pulses is below the host's filter, so the pair reads as one.
    check_cnt(n_irq, 2);
    $display("test interrupt done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i) {en, cfg} <= 2'(i);
      step(12);
      check_bit(chg_en, i == 3);
    end
    @(posedge clk_i) therm <= 1'b0;
    step(3);
    check_bit(suspend, 1'b1);
    @(posedge clk_i) therm <= 1'b1;
    step(3);
    check_bit(suspend, 1'b0);
    $display("test charge enable done");
    pulse(2);
    step(2);
    check_bit(ship, 1'b1);
    check_bit(sw_on, 1'b0);
    pulse(3);
    wait_for(2, 1'b1);
    run_len(2, 1'b1, n);
    check_cnt(n, 40);
    check_bit(ship, 1'b0);
    check_bit(sw_on, 1'b1);
    $display("test ship exit done");
    @(posedge clk_i) src_pres <= 1'b0;
    pulse(4);
    wait_for(3, 1'b1);
    check_bit(sw_on, 1'b0);
    run_len(3, 1'b1, n);
    check_cnt(n, 10);
    check_bit(sw_on, 1'b1);
    wait_for(4, 1'b0);
    step(8);
    check_bit(sys_rst, 1'b0);
    @(posedge clk_i) src_pres <= 1'b1;
    $display("test system reset done");
    @(posedge clk_i) sw_dis <= 1'b1;
    step(2);
    check_bit(sw_on, 1'b0);
    @(posedge clk_i) sw_dis <= 1'b0;
    step(2);
    check_bit(sw_on, 1'b1);
    @(posedge clk_i) {src_pres, bat_pres} <= 2'b00;
    step(2);
    check_bit(pins.switch_ctrl_pullup, 1'b0);
    @(posedge clk_i) {src_pres, bat_pres} <= 2'b01;
    step(2);
    check_bit(pins.switch_ctrl_pullup, 1'b1);
    $display("test switch disable done");
    final_report();
  end
endmodule
